/* File: logic_cell_array.v */
// One row of logic cells: a carry-chained bank for adders and counters and cascade chains over groups.
// Assumes a single fabric clock; all inputs come from logic on that clock, so no synchronisers are used.
`include "logic_cell_defines.vh"
module logic_cell_array (
    input  wire                          CLK,
    input  wire                          NRST,
    input  wire [`MODE_W-1:0]            MODE,
    input  wire                          REG_BYPASS,
    input  wire                          CE_FROM_FIRST_DATA_INPUT,
    input  wire                          CLR,
    input  wire                          PRESET,
    input  wire [`ADD_BITS-1:0]          OPERAND_A,
    input  wire [`ADD_BITS-1:0]          OPERAND_B,
    input  wire [`ADD_BITS-1:0]          FIRST_DATA_INPUT,
    input  wire                          CARRY_IN,
    input  wire                          COUNT_UP,
    input  wire [`ADD_BITS-1:0]          LOAD_VALUE,
    input  wire                          LOAD,
    input  wire                          CASC_OP,
    input  wire [`GROUP_INPUTS*`GROUPS_PER_ROW-1:0] CASC_DATA,
    input  wire [`GROUPS_PER_ROW*`CELLS_PER_GROUP-1:0] CASC_LUT_MASK,
    output reg  [`ADD_BITS-1:0]          CELL_OUT,
    output reg                           CARRY_CELL_OUT,
    output reg                           CASC_LEFT_EVEN,
    output reg                           CASC_LEFT_ODD,
    output reg                           CASC_RIGHT_EVEN,
    output reg                           CASC_RIGHT_ODD
);
    localparam NB = `ADD_BITS;
    localparam NC = `CELLS_PER_GROUP;
    localparam NG = `GROUPS_PER_ROW;
    localparam HALF = NG / 2;

    // Per-cell table: a 4-input function, here the AND of the inputs masked by a per-cell enable.
    // Leaving a cell masked makes it transparent to the chain, so short functions need no padding.
    function cell_lut;
        input [3:0] d;
        input       en;
        begin
            cell_lut = en ? (&d) : 1'b1;
        end
    endfunction

    // The adder output skips the register only in arithmetic mode with the bypass set.
    function is_bypass;
        input [`MODE_W-1:0] m;
        input               byp;
        begin
            is_bypass = (m == `MODE_ARITH) && byp;
        end
    endfunction

    // The first two groups of each half start a fresh chain, so nothing crosses the memory.
    function starts_chain;
        input integer g;
        begin
            starts_chain = (g < 2) || (g == HALF) || (g == HALF + 1);
        end
    endfunction

    // Full-adder cell: sum and carry from the two operand bits and the incoming carry.
    function [1:0] sum_carry;
        input a;
        input b;
        input c;
        reg   s;
        reg   co;
        begin
            s = a ^ b ^ c;
            co = (a & b) | (a & c) | (b & c);
            sum_carry = {co, s};
        end
    endfunction

    reg  [NB-1:0] flop_q;
    reg  [NB-1:0] flop_d;
    reg           carry_q;
    wire [NB:0]   carry;
    wire [NB-1:0] sum;
    reg  [NB-1:0] opnd_b;
    reg           carry_first;
    wire [NB-1:0] ce;

    localparam [NB-1:0] STEP_ONE = {{(NB-1){1'b0}}, 1'b1};

    // In counter modes the second operand is a fixed step and the first comes from the flop feedback.
    always @*
    begin
        carry_first = 1'b0;
        opnd_b = OPERAND_B;
        case (MODE)
            `MODE_NORMAL:
            begin
                carry_first = 1'b0;
                opnd_b = OPERAND_B;
            end
            `MODE_ARITH:
            begin
                carry_first = CARRY_IN;
                opnd_b = OPERAND_B;
            end
            `MODE_UPDOWN:
            begin
                carry_first = 1'b0;
                opnd_b = COUNT_UP ? STEP_ONE : {NB{1'b1}};
            end
            `MODE_CLRCNT:
            begin
                carry_first = 1'b0;
                opnd_b = STEP_ONE;
            end
            default:
            begin
                carry_first = 1'b0;
                opnd_b = OPERAND_B;
            end
        endcase
    end

    assign carry[0] = carry_first;

    genvar i;
    generate
        for (i = 0; i < NB; i = i + 1)
        begin : g_bit
            wire [1:0] sc;
            reg        a_in;
            reg        ce_bit;
            // Arithmetic mode with the register in the path is an accumulator.
            always @*
            begin
                if (is_bypass(MODE, REG_BYPASS))
                    a_in = OPERAND_A[i];
                else if (MODE == `MODE_NORMAL)
                    a_in = OPERAND_A[i];
                else
                    a_in = flop_q[i];
            end
            assign sc = sum_carry(a_in, opnd_b[i], carry[i]);
            assign sum[i] = sc[0];
            assign carry[i+1] = sc[1];
            always @*
            begin
                if (CE_FROM_FIRST_DATA_INPUT)
                    ce_bit = FIRST_DATA_INPUT[i];
                else
                    ce_bit = 1'b1;
            end
            assign ce[i] = ce_bit;
        end
    endgenerate

    always @*
    begin
        flop_d = flop_q;
        case (MODE)
            `MODE_NORMAL:
            begin
                flop_d = OPERAND_A & OPERAND_B;
            end
            `MODE_ARITH:
            begin
                flop_d = sum;
            end
            `MODE_UPDOWN, `MODE_CLRCNT:
            begin
                if (LOAD)
                    flop_d = LOAD_VALUE;
                else
                    flop_d = sum;
            end
            default:
            begin
                flop_d = flop_q;
            end
        endcase
    end

    generate
        for (i = 0; i < NB; i = i + 1)
        begin : g_flop
            // Clear outranks preset; both act even while the enable is low.
            always @(posedge CLK)
            begin
                if (!NRST)
                    flop_q[i] <= `CELL_RESET;
                else if (CLR)
                    flop_q[i] <= 1'b0;
                else if (PRESET)
                    flop_q[i] <= 1'b1;
                else if (ce[i])
                    flop_q[i] <= flop_d[i];
                else
                    flop_q[i] <= flop_q[i];
            end
        end
    endgenerate

    // The extra cell that turns the last carry into an ordinary signal: NB bit cells plus this one.
    always @(posedge CLK)
    begin
        if (!NRST)
            carry_q <= `CELL_RESET;
        else
            carry_q <= carry[NB];
    end

    // Top-module outputs are registered, so the bypassed sum appears one edge later and the carry cell output two edges later.
    always @(posedge CLK)
    begin
        if (!NRST)
            CELL_OUT <= {NB{1'b0}};
        else if (is_bypass(MODE, REG_BYPASS))
            CELL_OUT <= sum;
        else
            CELL_OUT <= flop_q;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
            CARRY_CELL_OUT <= 1'b0;
        else
            CARRY_CELL_OUT <= carry_q;
    end

    // Cascade: each group runs an eight-cell serial chain, four inputs per cell.
    wire [NG-1:0] grp_out;
    wire [NG-1:0] grp_in;
    generate
        for (i = 0; i < NG; i = i + 1)
        begin : g_group
            wire [NC:0] link;
            genvar k;
            assign link[0] = grp_in[i];
            for (k = 0; k < NC; k = k + 1)
            begin : g_cell
                wire [3:0] d;
                wire       lut;
                // OR is built as AND of inverted inputs with an inverted result.
                assign d = CASC_DATA[i*`GROUP_INPUTS+k*4 +: 4] ^ {4{CASC_OP}};
                assign lut = cell_lut(d, CASC_LUT_MASK[i*NC+k]);
                assign link[k+1] = link[k] & lut;
            end
            assign grp_out[i] = link[NC];
            // A chain longer than one group enters from two groups back, same parity.
            // Groups nearest the middle start fresh, so no chain crosses the memory.
            if (starts_chain(i))
            begin : g_start
                assign grp_in[i] = 1'b1;
            end
            else
            begin : g_link
                assign grp_in[i] = grp_out[i-2];
            end
        end
    endgenerate

    always @(posedge CLK)
    begin
        if (!NRST)
            CASC_LEFT_EVEN <= 1'b0;
        else
            CASC_LEFT_EVEN <= grp_out[HALF-2] ^ CASC_OP;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
            CASC_LEFT_ODD <= 1'b0;
        else
            CASC_LEFT_ODD <= grp_out[HALF-1] ^ CASC_OP;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
            CASC_RIGHT_EVEN <= 1'b0;
        else
            CASC_RIGHT_EVEN <= grp_out[NG-2] ^ CASC_OP;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
            CASC_RIGHT_ODD <= 1'b0;
        else
            CASC_RIGHT_ODD <= grp_out[NG-1] ^ CASC_OP;
    end
endmodule

/* File: logic_cell_defines.vh */
// Constants for the logic cell array: mode codes, chain geometry and reset values.
// Assumes it is included by the array module, the checker and the bench, by its bare name.
`ifndef LOGIC_CELL_DEFINES_VH
`define LOGIC_CELL_DEFINES_VH
`define MODE_W          2
`define MODE_NORMAL     2'h0
`define MODE_ARITH      2'h1
`define MODE_UPDOWN     2'h2
`define MODE_CLRCNT     2'h3
`define ADD_BITS        8
`define CELLS_PER_GROUP 8
`define GROUPS_PER_ROW  4
`define GROUP_INPUTS    32
`define CASC_AND        1'h0
`define CASC_OR         1'h1
`define CELL_RESET      1'h0
`endif

/* File: cell_chk_sva.sv */
// Assertions on the logic cell array ports.
// Assumes one clock with a synchronous active-low reset.
`include "logic_cell_defines.vh"
module cell_chk (
    input wire logic         CLK, NRST, REG_BYPASS, CE_FROM_FIRST_DATA_INPUT, CLR, PRESET, CARRY_IN, COUNT_UP, LOAD,
    input wire logic         CASC_OP, CARRY_CELL_OUT, CASC_LEFT_EVEN,
    input wire logic [1:0]   MODE,
    input wire logic [7:0]   OPERAND_A, OPERAND_B, FIRST_DATA_INPUT, CELL_OUT,
    input wire logic [127:0] CASC_DATA,
    input wire logic [31:0]  CASC_LUT_MASK
);
    wire       byp = MODE == `MODE_ARITH && REG_BYPASS;
    wire       q = !CLR && !PRESET && !CE_FROM_FIRST_DATA_INPUT;
    wire [8:0] s = OPERAND_A + OPERAND_B + CARRY_IN;
    function automatic logic grp0(input logic [31:0] d, input logic [7:0] m, input logic op);
        logic t;
        t = 1'b1;
        for (int k = 0; k < 8; k++)
            if (m[k])
                t = t & (&(d[k*4 +: 4] ^ {4{op}}));
        return t ^ op;
    endfunction
    wire       e0 = grp0(CASC_DATA[31:0], CASC_LUT_MASK[7:0], CASC_OP);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_sum; byp && q |=> CELL_OUT == $past(s[7:0]); endproperty
    a_sum: assert property (p_sum) else $error("sum");
    property p_cry; byp && q |-> ##2 CARRY_CELL_OUT == $past(s[8], 2); endproperty
    a_cry: assert property (p_cry) else $error("carry");
    property p_acc; MODE == `MODE_ARITH && !REG_BYPASS && q ##1 !byp
        |-> ##1 CELL_OUT == $past(CELL_OUT) + $past(OPERAND_B + CARRY_IN, 2); endproperty
    a_acc: assert property (p_acc) else $error("accumulate");
    property p_cnt; MODE == `MODE_UPDOWN && q && !LOAD ##1 !byp
        |-> ##1 CELL_OUT == $past(CELL_OUT) + ($past(COUNT_UP, 2) ? 8'h01 : 8'hff); endproperty
    a_cnt: assert property (p_cnt) else $error("count");
    property p_hld; !byp && CE_FROM_FIRST_DATA_INPUT && FIRST_DATA_INPUT == 8'h00 && !CLR && !PRESET
        ##1 !byp |-> ##1 $stable(CELL_OUT); endproperty
    a_hld: assert property (p_hld) else $error("hold");
    property p_clr; CLR && !byp ##1 !byp |-> ##1 CELL_OUT == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_pre; PRESET && !CLR && !byp ##1 !byp |-> ##1 CELL_OUT == 8'hff; endproperty
    a_pre: assert property (p_pre) else $error("preset");
    property p_cas; NRST |=> CASC_LEFT_EVEN == $past(e0); endproperty
    a_cas: assert property (p_cas) else $error("cascade");
    cover property (byp && s[8]);
    cover property (CE_FROM_FIRST_DATA_INPUT && FIRST_DATA_INPUT == 8'h00);
    cover property (MODE == `MODE_UPDOWN && !COUNT_UP);
    cover property (CASC_OP == `CASC_OR && !e0);
endmodule
bind logic_cell_array cell_chk u_chk (.*);

/* File: tb_logic_cell_array.sv */
// Bench for the logic cell array: an adder run, then a register run in random modes.
// Assumes the checker is compiled first; cascade op, mask and data are drawn at random each cycle.
`include "logic_cell_defines.vh"
module tb_logic_cell_array;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int due; int k; logic [7:0] v;} note_t;
    note_t nq[$];
    logic clk = 0, nrst = 0, byp = 1, ce = 0, clr = 0, pre = 0, ci = 0, up = 0, ld = 0;
    logic [1:0] mode = `MODE_ARITH;
    logic [7:0] a = 0, b = 0, fdi = 0, lv = 0, co, acc, n;
    logic [15:0] r = 16'h0044;
    logic [127:0] cd = 0;
    logic [31:0] cm = 0;
    logic cop = 0, cco;
    logic [3:0] cso;
    int cyc = 0, err_count = 0, check_count = 0;
    logic_cell_array dut (.CLK(clk), .NRST(nrst), .MODE(mode), .REG_BYPASS(byp), .CE_FROM_FIRST_DATA_INPUT(ce), .CLR(clr),
        .PRESET(pre), .OPERAND_A(a), .OPERAND_B(b), .FIRST_DATA_INPUT(fdi), .CARRY_IN(ci), .COUNT_UP(up),
        .LOAD_VALUE(lv), .LOAD(ld), .CASC_OP(cop), .CASC_DATA(cd), .CASC_LUT_MASK(cm), .CELL_OUT(co),
        .CARRY_CELL_OUT(cco), .CASC_LEFT_EVEN(cso[0]), .CASC_LEFT_ODD(cso[1]), .CASC_RIGHT_EVEN(cso[2]),
        .CASC_RIGHT_ODD(cso[3]));
    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // AND of all unmasked inputs per group, or OR of them; an empty chain gives the neutral value.
    function automatic logic [3:0] casc_exp(input logic [127:0] d, input logic [31:0] m, input logic op);
        logic [3:0] t;
        t = {4{~op}};
        for (int g = 0; g < 4; g++)
            for (int k = 0; k < 8; k++)
                if (m[g*8+k])
                    t[g] = op ? (t[g] | (|d[g*32+k*4 +: 4])) : (t[g] & (&d[g*32+k*4 +: 4]));
        return t;
    endfunction
    task automatic miss(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk(input logic [7:0] e, g);
        miss("cell_out", e, g);
    endtask
    task automatic chk_carry(input logic e, g);
        miss("carry_cell_out", {7'h00, e}, {7'h00, g});
    endtask
    task automatic chk_casc(input logic [3:0] e, g);
        miss("cascade_ends", {4'h0, e}, {4'h0, g});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Notes the result due d edges later, then moves to the next random draw.
    task automatic tick(input logic [8:0] e, input int d, input bit cy);
        nq.push_back('{cyc + d, 0, e[7:0]});
        if (cy)
            nq.push_back('{cyc + 2, 1, {7'h00, e[8]}});
        @(negedge clk);
        r = lfsr(r);
        cd = {4{r, r}} | {128{r[12]}};
        cm = {r[7:0], r[15:8], r};
        cop = r[11];
        nq.push_back('{cyc + 1, 2, {4'h0, casc_exp(cd, cm, cop)}});
    endtask
    always @(negedge clk)
        while (nq.size() > 0 && nq[0].due == cyc)
        begin
            case (nq[0].k)
                0: chk(nq[0].v, co);
                1: chk_carry(nq[0].v[0], cco);
                default: chk_casc(nq[0].v[3:0], cso);
            endcase
            void'(nq.pop_front());
        end
    initial
    begin
        repeat (8) @(negedge clk);
        nrst = 1;
        @(negedge clk);
        for (int i = 0; i < 40; i++)
        begin
            {a, b, ci} = i ? {r, r[3]} : 17'h1ffff;
            tick(a + b + ci, 1, 1);
        end
        $display("adder test done");
        // The first cycle clears the register, since the adder run left it holding its last sum, which acc does not track.
        byp = 0;
        for (int i = 0; i < 150; i++)
        begin
            mode = i < 2 ? `MODE_ARITH : r[1:0];
            {ce, up, ci, a, b} = {r[4:2], r};
            ld = r[5];
            clr = i == 0 || r[9:6] == 0;
            pre = i == 1 || r[9:6] == 1;
            fdi = r[6:5] ? r[15:8] : 8'h00;
            lv = r[13:6];
            case (mode)
                `MODE_NORMAL: n = a & b;
                `MODE_ARITH: n = acc + b + ci;
                default: n = ld ? lv : acc + (mode == `MODE_UPDOWN && !up ? 8'hff : 8'h01);
            endcase
            if (ce) n = n & fdi | acc & ~fdi;
            acc = clr ? 8'h00 : pre ? 8'hff : n;
            tick(acc, 2, 0);
        end
        repeat (3) @(negedge clk);
        if (nq.size() != 0)
            err_count++;
        $display("register test done");
        report_and_stop();
    end
    initial
    begin
        #20000 err_count++;
        report_and_stop();
    end
endmodule
